// >>> flsp_map.svh
/*
 * Constants of the flash self-programming sequencer: command codes, control
 * bit positions, the command window and the erased-word value.
 * Assumes it is included by bare name from the sequencer's design files.
 */
`ifndef FLSP_MAP_SVH
`define FLSP_MAP_SVH

`define FLSP_CMD_ERASE      8'h03
`define FLSP_CMD_LOAD       8'h01
`define FLSP_CMD_WRITE      8'h05
`define FLSP_CMD_MASK       8'h07
`define FLSP_STORE_EN_BIT   0
`define FLSP_CLEAR_BUF_BIT  4
`define FLSP_WINDOW_CYCLES  3'h4
`define FLSP_ERASED_WORD    16'hffff
`define FLSP_BLOCK_MASK     15'h7ffc

`endif

// >>> flsp_pkg.sv
/*
 * Types shared by the flash self-programming sequencer.
 * Assumes no other package; nothing here is imported elsewhere.
 */
package flsp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_ERASE_WAIT,
        ST_STREAM,
        ST_DRAIN,
        ST_WRITE_WAIT
    } flsp_state_type;

    // Request towards the flash array macro.
    typedef struct packed {
        logic        erase_start;
        logic        write_start;
        logic        data_valid;
        logic [14:0] page;
        logic [7:0]  word;
        logic [15:0] data;
    } flsp_flash_req_type;

endpackage

// >>> flsp_page_buf.sv
/*
 * Temporary page buffer storage: one write port, one read port with the
 * read data held in a register. Assumes a single clock domain.
 */
`timescale 1ns/1ns
module flsp_page_buf #(
    parameter int DEPTH = 16,
    parameter int AW    = 4,
    parameter int DW    = 16
) (
    input  wire logic          sys_clk,
    input  wire logic          reset,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data_q
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= mem[rd_addr];
        end
    end
endmodule

// >>> flsp_sequencer.sv
/*
 * Flash self-programming sequencer: command arming, buffer loads, block
 * erase and page write towards the flash array, read byte select.
 * Assumes the CPU core pulses spm_exec and lpm_req on sys_clk and holds the
 * pointer bytes valid in that cycle; the flash macro pulses flash_done.
 */
`timescale 1ns/1ns
`include "flsp_map.svh"
// Operation
// - Each buffer-load command stores exactly one word.
// - Buffer may load before or after erase; erase leaves buffer intact.
// - Block erase clears four consecutive pages in one operation.
// - Buffer words may be loaded in any order.
// - Store instruction works only when the enable fuse reads zero.
// - Addresses come from the 16-bit pointer of high and low bytes.
// - Word address splits into word-in-page and page fields.
// - Page field picks one page for load/write, a block for erase.
// - Counter top bit sits one pointer bit higher; higher bits ignored.
// - Word field addresses buffer on load; software zeroes it on write.
// - Word field top bit sits one pointer bit higher too.
// - Pointer bit zero selects the byte on program-memory reads.
// - Address is latched when an operation starts.
// - Command codes arm; store must follow within four cycles.
// - CPU halted for the whole erase or write.
// - Buffer clears after page write, clear bit, and reset.
// - Store enable clears after store or timeout; held during operations.
module flsp_sequencer #(
    parameter int PAGE_WORDS = 16,
    parameter int PC_WIDTH   = 13
) (
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    input  wire logic                        self_program_enable_fuse_n,
    input  wire logic                        ctrl_wr,
    input  wire logic [7:0]                  ctrl_wdata,
    input  wire logic                        spm_exec,
    input  wire logic [7:0]                  pointer_high_byte,
    input  wire logic [7:0]                  pointer_low_byte,
    input  wire logic [15:0]                 spm_data,
    input  wire logic                        lpm_req,
    input  wire logic [15:0]                 lpm_word,
    input  wire logic                        flash_done,
    output logic      [7:0]                  ctrl_q,
    output logic                             cpu_halt_q,
    output logic                             fuse_en_q,
    output flsp_pkg::flsp_flash_req_type     flash_req_q,
    output logic      [7:0]                  lpm_byte_q
);
    localparam int WB = $clog2(PAGE_WORDS);
    localparam int PB = PC_WIDTH - WB;
    localparam logic [14:0] PAGE_MASK = 15'((32'd1 << PB) - 32'd1);

    flsp_pkg::flsp_state_type     state_q, state_d;
    flsp_pkg::flsp_flash_req_type req_d;
    logic [7:0]            ctrl_d, lpm_byte_d;
    logic [2:0]            win_q, win_d;
    logic                  halt_d;
    logic [PAGE_WORDS-1:0] valid_q, valid_d, load_hit;
    logic [WB-1:0]         idx_q, idx_d, word1_q;
    logic                  pend1_q, rd_en;
    logic                  fuse_meta_q;
    logic [15:0]           z;
    logic [WB-1:0]         word_field;
    logic [14:0]           page_field;
    logic                  accept, mem_we;
    logic [15:0]           rd_data;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    assign z          = {pointer_high_byte, pointer_low_byte};
    assign word_field = z[WB:1];
    assign page_field = (z[15:1] >> WB) & PAGE_MASK;
    assign accept     = spm_exec && state_q == flsp_pkg::ST_ARMED && fuse_en_q && win_q != 3'h0;
    assign mem_we     = accept && (ctrl_q & `FLSP_CMD_MASK) == `FLSP_CMD_LOAD;

    // Each entry remembers whether it was loaded; unloaded entries read as erased.
    for (genvar i = 0; i < PAGE_WORDS; i++) begin : g_hit
        assign load_hit[i] = mem_we && word_field == WB'(i);
    end

    flsp_page_buf #(.DEPTH(PAGE_WORDS), .AW(WB), .DW(16)) u_buf (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .wr_en     (mem_we),
        .wr_addr   (word_field),
        .wr_data   (spm_data),
        .rd_addr   (idx_q),
        .rd_data_q (rd_data)
    );

    // The fuse is a pad level, so it is synchronised before any use.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fuse_meta_q <= 1'b0;
            fuse_en_q   <= 1'b0;
        end else begin
            fuse_meta_q <= !self_program_enable_fuse_n;
            fuse_en_q   <= fuse_meta_q;
        end
    end

    always_comb begin
        state_d    = state_q;
        ctrl_d     = ctrl_q;
        win_d      = (win_q != 3'h0) ? win_q - 3'h1 : 3'h0;
        halt_d     = cpu_halt_q;
        valid_d    = valid_q;
        idx_d      = idx_q;
        rd_en      = 1'b0;
        lpm_byte_d = lpm_byte_q;
        req_d      = flash_req_q;
        req_d.erase_start = 1'b0;
        req_d.write_start = 1'b0;
        req_d.data_valid  = pend1_q;
        req_d.word        = 8'(word1_q);
        req_d.data        = valid_q[word1_q] ? rd_data : `FLSP_ERASED_WORD;
        if (lpm_req) begin
            lpm_byte_d = z[0] ? lpm_word[15:8] : lpm_word[7:0];
        end
        unique case (state_q)
            flsp_pkg::ST_IDLE, flsp_pkg::ST_ARMED: begin
                if (state_q == flsp_pkg::ST_ARMED && !accept && win_q == 3'h1) begin
                    ctrl_d  = 8'h00;
                    state_d = flsp_pkg::ST_IDLE;
                end
                if (accept) begin
                    req_d.page = page_field;
                    idx_d      = '0;
                    if ((ctrl_q & `FLSP_CMD_MASK) == `FLSP_CMD_ERASE) begin
                        req_d.page        = page_field & `FLSP_BLOCK_MASK;
                        req_d.erase_start = 1'b1;
                        halt_d            = 1'b1;
                        state_d           = flsp_pkg::ST_ERASE_WAIT;
                    end else if ((ctrl_q & `FLSP_CMD_MASK) == `FLSP_CMD_WRITE) begin
                        halt_d  = 1'b1;
                        state_d = flsp_pkg::ST_STREAM;
                    end else begin
                        ctrl_d  = 8'h00;
                        state_d = flsp_pkg::ST_IDLE;
                    end
                end
                if (ctrl_wr && !accept) begin
                    if (ctrl_wdata[`FLSP_CLEAR_BUF_BIT]) begin
                        valid_d = '0;
                    end
                    if (ctrl_wdata[`FLSP_STORE_EN_BIT]) begin
                        ctrl_d  = ctrl_wdata & `FLSP_CMD_MASK;
                        win_d   = `FLSP_WINDOW_CYCLES;
                        state_d = flsp_pkg::ST_ARMED;
                    end
                end
                valid_d = valid_d | load_hit;
            end
            flsp_pkg::ST_ERASE_WAIT: begin
                // The buffer is left untouched so it can be loaded before the erase.
                if (flash_done) begin
                    halt_d  = 1'b0;
                    ctrl_d  = 8'h00;
                    state_d = flsp_pkg::ST_IDLE;
                end
            end
            flsp_pkg::ST_STREAM: begin
                rd_en = 1'b1;
                idx_d = idx_q + WB'(1);
                if (idx_q == WB'(PAGE_WORDS - 1)) begin
                    state_d = flsp_pkg::ST_DRAIN;
                end
            end
            flsp_pkg::ST_DRAIN: begin
                if (!pend1_q) begin
                    req_d.write_start = 1'b1;
                    state_d           = flsp_pkg::ST_WRITE_WAIT;
                end
            end
            flsp_pkg::ST_WRITE_WAIT: begin
                if (flash_done) begin
                    valid_d = '0;
                    halt_d  = 1'b0;
                    ctrl_d  = 8'h00;
                    state_d = flsp_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q     <= flsp_pkg::ST_IDLE;
            ctrl_q      <= 8'h00;
            win_q       <= 3'h0;
            cpu_halt_q  <= 1'b0;
            valid_q     <= '0;
            idx_q       <= '0;
            word1_q     <= '0;
            pend1_q     <= 1'b0;
            flash_req_q <= '0;
            lpm_byte_q  <= 8'h00;
        end else begin
            state_q     <= state_d;
            ctrl_q      <= ctrl_d;
            win_q       <= win_d;
            cpu_halt_q  <= halt_d;
            valid_q     <= valid_d;
            idx_q       <= idx_d;
            word1_q     <= idx_q;
            pend1_q     <= rd_en;
            flash_req_q <= req_d;
            lpm_byte_q  <= lpm_byte_d;
        end
    end

    one_word_load_a: assert property (mem_we |=> !mem_we)
        else $error("two buffer loads from one command");
    erase_keeps_buf_a: assert property (state_q == flsp_pkg::ST_ERASE_WAIT |=> valid_q == $past(valid_q))
        else $error("block erase disturbed the page buffer");
    erase_block_page_a: assert property (flash_req_q.erase_start |-> flash_req_q.page[1:0] == 2'b00)
        else $error("erase block not aligned to four pages");
    fuse_gates_ops_a: assert property (!fuse_en_q && state_q == flsp_pkg::ST_ARMED |=>
        state_q != flsp_pkg::ST_ERASE_WAIT && state_q != flsp_pkg::ST_STREAM && !$rose(valid_q != '0))
        else $error("store accepted while fuse disabled");
    load_word_addr_a: assert property (mem_we |=> valid_q[$past(word_field)])
        else $error("load did not mark the addressed word");
    addr_latched_a: assert property (state_q == flsp_pkg::ST_ERASE_WAIT &&
        $past(state_q) == flsp_pkg::ST_ERASE_WAIT |-> $stable(flash_req_q.page))
        else $error("latched address changed during erase");
    arm_window_a: assert property (state_q == flsp_pkg::ST_IDLE && ctrl_wr && ctrl_wdata[0]
        ##1 (!spm_exec && !ctrl_wr) [*4] |=> state_q == flsp_pkg::ST_IDLE && ctrl_q == 8'h00)
        else $error("command window longer than four cycles");
    halt_during_op_a: assert property (state_q inside {flsp_pkg::ST_ERASE_WAIT, flsp_pkg::ST_STREAM,
        flsp_pkg::ST_DRAIN, flsp_pkg::ST_WRITE_WAIT} |-> cpu_halt_q && ctrl_q[0])
        else $error("cpu not halted or enable dropped during operation");
    clear_after_write_a: assert property (state_q == flsp_pkg::ST_WRITE_WAIT && flash_done |=> valid_q == '0)
        else $error("buffer not cleared after page write");
    lpm_byte_sel_a: assert property (lpm_req |=> lpm_byte_q == ($past(z[0]) ? $past(lpm_word[15:8])
        : $past(lpm_word[7:0])))
        else $error("wrong byte returned for read");
endmodule

// >>> flsp_flash_model.sv
/*
 * Stand-in for the flash array behind the self-programming sequencer.
 * Assumes one clock; each start pulse is answered by a done pulse after a
 * delay that the bench chooses, so both quick and slow flash are seen.
 */
`timescale 1ns/1ns
module flsp_flash_model (
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    input  wire flsp_pkg::flsp_flash_req_type flash_req,
    input  wire logic [7:0]                   delay,
    output logic                              flash_done
);
    logic [7:0] cnt_q;
    logic       busy_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_q      <= 8'h00;
            busy_q     <= 1'b0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= 1'b0;
            if (flash_req.erase_start || flash_req.write_start) begin
                busy_q <= 1'b1;
                cnt_q  <= delay;
            end else if (busy_q && cnt_q == 8'h00) begin
                busy_q     <= 1'b0;
                flash_done <= 1'b1;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

// >>> flash_self_programming_sequencer_tb.sv
/*
 * Self-checking bench of the flash self-programming sequencer.
 * Assumes the sequencer with 16-word pages and a 13-bit counter; the bench
 * plays the CPU core and the model answers for the flash array.
 */
`timescale 1ns/1ns
`include "flsp_map.svh"
module flash_self_programming_sequencer_tb;
    logic                         sys_clk, reset, fuse_n, ctrl_wr, spm_exec, lpm_req, flash_done;
    logic                         cpu_halt_q, fuse_en_q;
    logic [7:0]                   ctrl_wdata, ptr_hi, ptr_lo, ctrl_q, lpm_byte_q, delay;
    logic [15:0]                  spm_data, lpm_word, z;
    logic [15:0]                  buf_m [16];
    flsp_pkg::flsp_flash_req_type flash_req_q, got, exp;
    flsp_pkg::flsp_flash_req_type exp_q [$];
    int                           num_errors, check_count, i;

    flsp_sequencer #(.PAGE_WORDS(16), .PC_WIDTH(13)) dut (
        .sys_clk(sys_clk), .reset(reset), .self_program_enable_fuse_n(fuse_n), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .spm_exec(spm_exec), .pointer_high_byte(ptr_hi), .pointer_low_byte(ptr_lo),
        .spm_data(spm_data), .lpm_req(lpm_req), .lpm_word(lpm_word), .flash_done(flash_done),
        .ctrl_q(ctrl_q), .cpu_halt_q(cpu_halt_q), .fuse_en_q(fuse_en_q), .flash_req_q(flash_req_q),
        .lpm_byte_q(lpm_byte_q));
    flsp_flash_model flash (.sys_clk(sys_clk), .reset(reset), .flash_req(flash_req_q), .delay(delay),
        .flash_done(flash_done));

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic stop_test();
        if (exp_q.size() != 0) check(1'b0, "flash requests still due at end");
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic flsp_pkg::flsp_flash_req_type mk(input logic e, input logic w, input logic v,
        input logic [14:0] p, input logic [7:0] wd, input logic [15:0] d);
        mk = '{e, w, v, p, wd, d};
    endfunction

    // Pointer bytes are scrambled once the store is taken, so a design that
    // fails to latch the address shows a wrong page on the flash side.
    task automatic cmd(input logic [7:0] code, input logic [15:0] zp, input logic [15:0] d, input logic store_program_memory_instruction);
        int k;
        ctrl_wr = 1'b1;
        ctrl_wdata = code;
        @(negedge sys_clk);
        ctrl_wr = 1'b0;
        check(ctrl_q === (code & `FLSP_CMD_MASK), "armed command");
        if (store_program_memory_instruction) begin
            {ptr_hi, ptr_lo} = zp;
            spm_data = d;
            spm_exec = 1'b1;
            delay = 8'(3 + $urandom % 40);
            @(negedge sys_clk);
            spm_exec = 1'b0;
            {ptr_hi, ptr_lo} = ~zp;
        end else repeat (4) @(negedge sys_clk);
        // A refused store only times out at the fourth edge after the arming write.
        repeat (3) @(negedge sys_clk);
        if (store_program_memory_instruction && (code[2] || code[1])) check(cpu_halt_q === 1'b1, "halt during operation");
        for (k = 0; k < 400 && cpu_halt_q !== 1'b0; k++) @(negedge sys_clk);
        check(ctrl_q === 8'h00, "command cleared");
    endtask

    task automatic load(input logic [3:0] w, input logic [15:0] d);
        z = 16'($urandom);
        z[4:1] = w;
        cmd(`FLSP_CMD_LOAD, z, d, 1'b1);
        buf_m[w] = d;
    endtask

    task automatic erase(input logic [8:0] p);
        exp_q.push_back(mk(1'b1, 1'b0, 1'b0, {6'h00, p} & `FLSP_BLOCK_MASK, 8'h00, 16'h0000));
        cmd(`FLSP_CMD_ERASE, {2'b11, p, 5'(($urandom))}, 16'($urandom), 1'b1);
    endtask

    task automatic write(input logic [8:0] p);
        for (int w = 0; w < 16; w++) exp_q.push_back(mk(1'b0, 1'b0, 1'b1, {6'h00, p}, 8'(w), buf_m[w]));
        exp_q.push_back(mk(1'b0, 1'b1, 1'b0, {6'h00, p}, 8'h00, 16'h0000));
        cmd(`FLSP_CMD_WRITE, {2'b00, p, 5'h00}, 16'($urandom), 1'b1);
        for (int w = 0; w < 16; w++) buf_m[w] = `FLSP_ERASED_WORD;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) begin
        if (!reset && (flash_req_q.erase_start || flash_req_q.write_start || flash_req_q.data_valid)) begin
            got = flash_req_q;
            if (!got.data_valid) begin
                got.word = 8'h00;
                got.data = 16'h0000;
            end
            if (exp_q.size() == 0) check(1'b0, "flash request with none due");
            else begin
                exp = exp_q.pop_front();
                check(got === exp, "flash request");
            end
        end
    end

    initial begin
        #(20 * 20000);
        $display("unexpected at %0t: watchdog expired", $time);
        num_errors++;
        stop_test();
    end

    initial begin
        {reset, fuse_n} = 2'b11;
        {ctrl_wr, spm_exec, lpm_req} = 3'b000;
        {ctrl_wdata, ptr_hi, ptr_lo, delay} = 32'h0000_0005;
        {spm_data, lpm_word} = 32'h0000_0000;
        num_errors = 0;
        check_count = 0;
        void'($urandom(69));
        for (i = 0; i < 16; i++) buf_m[i] = `FLSP_ERASED_WORD;
        repeat (12) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        cmd(`FLSP_CMD_LOAD, 16'h0006, 16'h1234, 1'b1);
        check(fuse_en_q === 1'b0, "fuse blocks stores");
        fuse_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(fuse_en_q === 1'b1, "fuse enables stores");
        for (i = 0; i < 6; i++) load(4'($urandom), 16'($urandom));
        erase(9'h0a7);
        write(9'h0a5);
        // Page 9'h0a4 of the erased block is also written back, from one newly loaded word.
        load(4'h3, 16'h0c3c);
        write(9'h0a4);
        load(4'hf, 16'h5a5a);
        load(4'h0, 16'ha5a5);
        cmd(8'h10, 16'h0000, 16'h0000, 1'b0);
        for (i = 0; i < 16; i++) buf_m[i] = `FLSP_ERASED_WORD;
        cmd(`FLSP_CMD_LOAD, 16'h0004, 16'hbeef, 1'b0);
        {ptr_hi, ptr_lo} = 16'h0004;
        spm_exec = 1'b1;
        @(negedge sys_clk);
        spm_exec = 1'b0;
        erase(9'h1fd);
        write(9'h1fe);
        load(4'h7, 16'h7e7e);
        reset = 1'b1;
        @(negedge sys_clk);
        reset = 1'b0;
        check(ctrl_q === 8'h00 && cpu_halt_q === 1'b0 && fuse_en_q === 1'b0, "outputs after reset");
        for (i = 0; i < 16; i++) buf_m[i] = `FLSP_ERASED_WORD;
        repeat (3) @(negedge sys_clk);
        write(9'h1ff);
        for (i = 0; i < 2; i++) begin
            lpm_word = 16'($urandom);
            ptr_lo = {7'($urandom), i[0]};
            lpm_req = 1'b1;
            @(negedge sys_clk);
            lpm_req = 1'b0;
            check(lpm_byte_q === (i[0] ? lpm_word[15:8] : lpm_word[7:0]), "read byte select");
            @(negedge sys_clk);
        end
        repeat (4) @(negedge sys_clk);
        stop_test();
    end
endmodule
